//--- inc/ppo_pkg.sv
`default_nettype none

package ppo_pkg;

	// ----------------------------------------------------------------
	// Port geometry and register reset values
	// ----------------------------------------------------------------
	localparam int   PPO_PORT_WIDTH   = 8;
	localparam logic PPO_BIT_RESET    = 1'h0;
	localparam int   PPO_SYNC_STAGES  = 2;

	// ----------------------------------------------------------------
	// Pull-up decode: {direction, output value, global off}
	// ----------------------------------------------------------------
	localparam logic [2:0] PPO_PULLUP_ON_CODE = 3'h2;

	// ----------------------------------------------------------------
	// Read-back source selection
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PPO_RD_HOLD = 2'h0,
		PPO_RD_OUT  = 2'h1,
		PPO_RD_PIN  = 2'h2,
		PPO_RD_DIR  = 2'h3
	} ppo_rdsel_e;

endpackage

`default_nettype wire

//--- hw/ppo_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ppo_pin_sync #(
	parameter int WIDTH = ppo_pkg::PPO_PORT_WIDTH
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] asyncIn,
	output var  logic [WIDTH-1:0] syncOut
);
	import ppo_pkg::*;

	// ----------------------------------------------------------------
	// Two-stage synchroniser
	// ----------------------------------------------------------------
	// The first stage feeds only the second, so a metastable value never
	// reaches any decision logic.
	logic [WIDTH-1:0] stageA;
	logic [WIDTH-1:0] next_stageA;
	logic [WIDTH-1:0] next_syncOut;

	always_comb begin
		if (!rst_b) begin
			next_stageA  = {WIDTH{PPO_BIT_RESET}};
			next_syncOut = {WIDTH{PPO_BIT_RESET}};
		end else begin
			next_stageA  = asyncIn;
			next_syncOut = stageA;
		end
	end

	always_ff @(posedge clk_sys) begin
		stageA  <= next_stageA;
		syncOut <= next_syncOut;
	end

endmodule

`default_nettype wire

//--- hw/ppo_port.sv
`timescale 1ns/1ps
`default_nettype none

module ppo_port #(
	parameter int WIDTH = ppo_pkg::PPO_PORT_WIDTH
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	// Shared by every port.
	input  wire logic             sleepClamp,
	input  wire logic             globalPullupOff,
	// Shared by every pin of this port.
	input  wire logic [WIDTH-1:0] writeData,
	input  wire logic             portOutWriteStrobe,
	input  wire logic             portToggleWriteStrobe,
	input  wire logic             portDirWriteStrobe,
	input  wire logic             portOutReadStrobe,
	input  wire logic             portPinReadStrobe,
	input  wire logic             portDirReadStrobe,
	output var  logic [WIDTH-1:0] readData,
	// One of each per pin, from the peripheral owning the pin.
	input  wire logic [WIDTH-1:0] pullupOvrEn,
	input  wire logic [WIDTH-1:0] pullupOvrVal,
	input  wire logic [WIDTH-1:0] dirOvrEn,
	input  wire logic [WIDTH-1:0] dirOvrVal,
	input  wire logic [WIDTH-1:0] outvalOvrEn,
	input  wire logic [WIDTH-1:0] outvalOvrVal,
	input  wire logic [WIDTH-1:0] inputGateOvrEn,
	input  wire logic [WIDTH-1:0] inputGateOvrVal,
	input  wire logic [WIDTH-1:0] extIntEnable,
	output logic      [WIDTH-1:0] altDigitalIn,
	// Analog pass-through, both directions.
	input  wire logic [WIDTH-1:0] padAnalogIn,
	output logic      [WIDTH-1:0] altAnalogIn,
	input  wire logic [WIDTH-1:0] altAnalogOut,
	input  wire logic [WIDTH-1:0] altAnalogOe,
	output logic      [WIDTH-1:0] padAnalogOut,
	output logic      [WIDTH-1:0] padAnalogOe,
	// Digital pad.
	input  wire logic [WIDTH-1:0] padIn,
	output logic      [WIDTH-1:0] padOut,
	output logic      [WIDTH-1:0] padOe,
	output logic      [WIDTH-1:0] padPullup,
	// Register state.
	output var  logic [WIDTH-1:0] pinDirectionBit,
	output var  logic [WIDTH-1:0] pinOutputValueBit,
	output logic      [WIDTH-1:0] pinInputSampleBit
);
	import ppo_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [WIDTH-1:0] ovrMux(
		input logic [WIDTH-1:0] en,
		input logic [WIDTH-1:0] val,
		input logic [WIDTH-1:0] base
	);
		ovrMux = (en & val) | (~en & base);
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] next_pinDirectionBit;
	logic [WIDTH-1:0] next_pinOutputValueBit;
	logic [WIDTH-1:0] next_readData;
	logic [WIDTH-1:0] regPullup;
	logic [WIDTH-1:0] driverEn;
	logic [WIDTH-1:0] drivenVal;
	logic [WIDTH-1:0] normalGate;
	logic [WIDTH-1:0] inputGate;
	ppo_rdsel_e       readSel;

	// ----------------------------------------------------------------
	// Direction and output value registers
	// ----------------------------------------------------------------
	// A toggle written in the same cycle as a plain write acts on the
	// freshly written value, so software sees both take effect.
	always_comb begin
		next_pinDirectionBit   = pinDirectionBit;
		next_pinOutputValueBit = pinOutputValueBit;
		if (!rst_b) begin
			next_pinDirectionBit   = {WIDTH{PPO_BIT_RESET}};
			next_pinOutputValueBit = {WIDTH{PPO_BIT_RESET}};
		end else begin
			if (portDirWriteStrobe) begin
				next_pinDirectionBit = writeData;
			end
			if (portOutWriteStrobe) begin
				next_pinOutputValueBit = writeData;
			end
			if (portToggleWriteStrobe) begin
				next_pinOutputValueBit = next_pinOutputValueBit ^ writeData;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		pinDirectionBit   <= next_pinDirectionBit;
		pinOutputValueBit <= next_pinOutputValueBit;
	end

	// ----------------------------------------------------------------
	// Read-back
	// ----------------------------------------------------------------
	// The pin sample wins over the other two if strobes ever collide.
	always_comb begin
		if (portPinReadStrobe) begin
			readSel = PPO_RD_PIN;
		end else if (portOutReadStrobe) begin
			readSel = PPO_RD_OUT;
		end else if (portDirReadStrobe) begin
			readSel = PPO_RD_DIR;
		end else begin
			readSel = PPO_RD_HOLD;
		end
		unique case (readSel)
			PPO_RD_HOLD: next_readData = readData;
			PPO_RD_OUT:  next_readData = pinOutputValueBit;
			PPO_RD_PIN:  next_readData = pinInputSampleBit;
			PPO_RD_DIR:  next_readData = pinDirectionBit;
		endcase
		if (!rst_b) begin
			next_readData = {WIDTH{PPO_BIT_RESET}};
		end
	end

	always_ff @(posedge clk_sys) begin
		readData <= next_readData;
	end

	// ----------------------------------------------------------------
	// Output driver and pull-up
	// ----------------------------------------------------------------
	// The pad path is combinational so that reset can float the pins
	// even with the clock stopped; a registered enable would wait for
	// an edge.
	always_comb begin
		driverEn  = ovrMux(dirOvrEn, dirOvrVal, pinDirectionBit);
		drivenVal = ovrMux(outvalOvrEn, outvalOvrVal, pinOutputValueBit);
		for (int i = 0; i < WIDTH; i++) begin
			regPullup[i] = ({pinDirectionBit[i], pinOutputValueBit[i], globalPullupOff}
				== PPO_PULLUP_ON_CODE);
		end
	end

	// Value override only matters where the overridden direction drives.
	assign padOe     = driverEn & {WIDTH{rst_b}};
	assign padOut    = drivenVal & padOe;
	assign padPullup = ovrMux(pullupOvrEn, pullupOvrVal, regPullup)
		& {WIDTH{rst_b}};

	// ----------------------------------------------------------------
	// Digital input path
	// ----------------------------------------------------------------
	// The clamp is shared by all ports; an enabled external interrupt
	// keeps its own pin live, unless the pin's input gate override is enabled, so it can still wake the device.
	assign normalGate   = {WIDTH{~sleepClamp}} | extIntEnable;
	assign inputGate    = ovrMux(inputGateOvrEn, inputGateOvrVal, normalGate);
	assign altDigitalIn = padIn & inputGate;

	ppo_pin_sync #(
		.WIDTH (WIDTH)
	) u_sync (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.asyncIn (altDigitalIn),
		.syncOut (pinInputSampleBit)
	);

	// ----------------------------------------------------------------
	// Analog pass-through
	// ----------------------------------------------------------------
	// No gating here: the analog path must work while the digital input
	// is clamped.
	assign altAnalogIn  = padAnalogIn;
	assign padAnalogOut = altAnalogOut;
	assign padAnalogOe  = altAnalogOe;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_clamp_ground: assert property (@(posedge clk_sys) disable iff (!rst_b)
		sleepClamp |-> (altDigitalIn & ~inputGateOvrEn & ~extIntEnable) == '0)
		else $error("Clamped input not grounded.");

	chk_int_unclamp: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(altDigitalIn & extIntEnable & ~inputGateOvrEn)
			== (padIn & extIntEnable & ~inputGateOvrEn))
		else $error("Interrupt pin still clamped.");

	chk_resume_edge: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(sleepClamp) |-> ((altDigitalIn & ~$past(altDigitalIn))
			& padIn & $past(padIn) & ~inputGateOvrEn & ~extIntEnable)
			== (padIn & $past(padIn) & ~inputGateOvrEn & ~extIntEnable))
		else $error("No edge on clamp release.");

	chk_reset_float: assert property (@(posedge clk_sys)
		!rst_b |-> (padOe == '0) && (padPullup == '0))
		else $error("Pin driven or pulled in reset.");

	chk_reset_now: assert property (@(posedge clk_sys)
		$fell(rst_b) |-> padOe == '0)
		else $error("Pins not floated at reset.");

	chk_pullup_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
		globalPullupOff |-> (padPullup & ~pullupOvrEn) == '0)
		else $error("Pull-up on while globally off.");

	chk_pullup_ovr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(padPullup & pullupOvrEn) == (pullupOvrVal & pullupOvrEn))
		else $error("Pull-up ignores override.");

	chk_dir_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
		portDirWriteStrobe ##1 rst_b |->
			(padOe & ~dirOvrEn) == ($past(writeData) & ~dirOvrEn))
		else $error("Driver enable misses direction write.");

	chk_dir_ovr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(padOe & dirOvrEn) == (dirOvrVal & dirOvrEn))
		else $error("Driver enable ignores override.");

	chk_toggle_out: assert property (@(posedge clk_sys) disable iff (!rst_b)
		portToggleWriteStrobe && !portOutWriteStrobe ##1 rst_b |->
			pinOutputValueBit == ($past(pinOutputValueBit) ^ $past(writeData)))
		else $error("Toggle write wrong.");

	chk_outval_ovr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(padOut & padOe) == (padOe & ((outvalOvrEn & outvalOvrVal)
			| (~outvalOvrEn & pinOutputValueBit))))
		else $error("Driven value wrong.");

	chk_gate_ovr: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(altDigitalIn & inputGateOvrEn) == (padIn & inputGateOvrEn & inputGateOvrVal))
		else $error("Input gate override ignored.");

	chk_sync_delay: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rst_b [*3] |-> pinInputSampleBit == $past(altDigitalIn, 2))
		else $error("Sample not two cycles behind.");

	chk_analog_pass: assert property (@(posedge clk_sys)
		(altAnalogIn == padAnalogIn) && (padAnalogOe == altAnalogOe)
			&& (padAnalogOut == altAnalogOut))
		else $error("Analog path gated.");

	// ----------------------------------------------------------------
	// Further checks
	// ----------------------------------------------------------------
	// These restate each rule from the pins alone, so a slip in the shared
	// helper function cannot hide behind an identical expectation.
	chk_pullup_code: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(padPullup & ~pullupOvrEn) == (~pinDirectionBit & pinOutputValueBit
			& {WIDTH{~globalPullupOff}} & ~pullupOvrEn))
		else $error("Pull-up decode wrong.");

	chk_dir_bit_one: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(padOe & ~dirOvrEn) == (pinDirectionBit & ~dirOvrEn))
		else $error("Direction bit not honoured.");

	chk_undriven_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(padOut & ~padOe) == '0)
		else $error("Value shown on undriven pin.");

	chk_gate_default: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(altDigitalIn & ~inputGateOvrEn & ~extIntEnable)
			== (padIn & {WIDTH{~sleepClamp}} & ~inputGateOvrEn & ~extIntEnable))
		else $error("Default input gate wrong.");

	chk_out_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
		portOutWriteStrobe && !portToggleWriteStrobe ##1 rst_b |->
			pinOutputValueBit == $past(writeData))
		else $error("Output value write lost.");

	chk_read_pin: assert property (@(posedge clk_sys) disable iff (!rst_b)
		portPinReadStrobe ##1 rst_b |-> readData == $past(pinInputSampleBit))
		else $error("Pin read returns wrong sample.");

	chk_read_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!portPinReadStrobe && !portOutReadStrobe && !portDirReadStrobe ##1 rst_b
			|-> $stable(readData))
		else $error("Read data changed without a strobe.");

endmodule

`default_nettype wire

//--- tb/ppo_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

module ppo_periph_model #(
	parameter int W = 8
) (
	input  wire logic [W-1:0]   clk_sys,
	input  wire logic [W-1:0]   claim,
	input  wire logic [8*W-1:0] ovrReq,
	output logic      [W-1:0]   pullupOvrEn,
	output logic      [W-1:0]   pullupOvrVal,
	output logic      [W-1:0]   dirOvrEn,
	output logic      [W-1:0]   dirOvrVal,
	output logic      [W-1:0]   outvalOvrEn,
	output logic      [W-1:0]   outvalOvrVal,
	output logic      [W-1:0]   inputGateOvrEn,
	output logic      [W-1:0]   inputGateOvrVal,
	input  wire logic [W-1:0]   padOut,
	input  wire logic [W-1:0]   padOe,
	input  wire logic [W-1:0]   padPullup,
	input  wire logic [W-1:0]   extDrv,
	input  wire logic [W-1:0]   extLvl,
	output logic      [W-1:0]   padIn
);
	// ----------------------------------------------------------------
	// Peripheral override sources
	// ----------------------------------------------------------------
	// Pins that no peripheral claims see every override held low.
	assign {pullupOvrEn, pullupOvrVal, dirOvrEn, dirOvrVal, outvalOvrEn, outvalOvrVal,
		inputGateOvrEn, inputGateOvrVal} = ovrReq & {8{claim}};

	// ----------------------------------------------------------------
	// Pad resolution
	// ----------------------------------------------------------------
	// A released pad with no pull wanders, so stale values cannot pass for driven ones.
	logic [W-1:0] lastPad;
	always_ff @(posedge clk_sys[0]) begin
		lastPad <= padIn;
	end
	assign padIn = (padOe & padOut) | (~padOe & extDrv & extLvl)
		| (~padOe & ~extDrv & (padPullup | ~lastPad));
endmodule

`default_nettype wire

//--- tb/port_pin_override_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none

module port_pin_override_logic_tb;
	import ppo_pkg::*;
	localparam int PE = 7, PV = 6, DE = 5, DV = 4, OE = 3, OV = 2, GE = 1, GV = 0;
	logic            clk_sys, rst_b, sleepClamp, globalPullupOff;
	logic [5:0]      strb;
	logic [7:0]      writeData, extIntEnable, claim, extDrv, extLvl, anIn, anOut, anOe;
	logic [7:0][7:0] ovr;
	logic [7:0]      readData, altDigitalIn, altAnalogIn, padAnalogOut, padAnalogOe;
	logic [7:0]      padIn, padOut, padOe, padPullup, dirBit, outBit, sampleBit;
	logic [7:0]      puEn, puVal, dEn, dVal, oEn, oVal, gEn, gVal, gate;
	int              err_count = 0;
	int              num_checks = 0;

	ppo_port ppo_port_inst (.clk_sys(clk_sys), .rst_b(rst_b), .sleepClamp(sleepClamp),
		.globalPullupOff(globalPullupOff), .writeData(writeData),
		.portOutWriteStrobe(strb[0]), .portToggleWriteStrobe(strb[1]),
		.portDirWriteStrobe(strb[2]), .portOutReadStrobe(strb[3]),
		.portPinReadStrobe(strb[4]), .portDirReadStrobe(strb[5]), .readData(readData),
		.pullupOvrEn(puEn), .pullupOvrVal(puVal), .dirOvrEn(dEn), .dirOvrVal(dVal),
		.outvalOvrEn(oEn), .outvalOvrVal(oVal), .inputGateOvrEn(gEn),
		.inputGateOvrVal(gVal), .extIntEnable(extIntEnable), .altDigitalIn(altDigitalIn),
		.padAnalogIn(anIn), .altAnalogIn(altAnalogIn), .altAnalogOut(anOut),
		.altAnalogOe(anOe), .padAnalogOut(padAnalogOut), .padAnalogOe(padAnalogOe),
		.padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
		.pinDirectionBit(dirBit), .pinOutputValueBit(outBit), .pinInputSampleBit(sampleBit));

	ppo_periph_model ppo_periph_model_inst (.clk_sys({8{clk_sys}}), .claim(claim),
		.ovrReq(ovr), .pullupOvrEn(puEn), .pullupOvrVal(puVal), .dirOvrEn(dEn),
		.dirOvrVal(dVal), .outvalOvrEn(oEn), .outvalOvrVal(oVal), .inputGateOvrEn(gEn),
		.inputGateOvrVal(gVal), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
		.extDrv(extDrv), .extLvl(extLvl), .padIn(padIn));

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input int idx, input logic [7:0] data);
		strb[idx] = 1'b1;
		writeData = data;
		@(negedge clk_sys);
		strb = '0;
		@(negedge clk_sys);
	endtask

	task automatic rd(input logic [5:0] mask, input logic [7:0] exp);
		strb = mask;
		@(negedge clk_sys);
		strb = '0;
		chk("readData", exp, readData);
		@(negedge clk_sys);
	endtask

	task automatic report_and_stop();
		if (err_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// The whole sequence needs about 81 cycles; the 3000-cycle limit leaves ample margin.
	initial begin
		#(50 * 3000);
		err_count++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_b, sleepClamp, globalPullupOff, strb, writeData, extIntEnable} = '0;
		{ovr, anIn, anOut, anOe, extLvl} = '0;
		claim = 8'hFF;
		extDrv = 8'hFF;
		repeat (4) @(negedge clk_sys);
		rst_b = 1'b1;
		wr(2, 8'h0F);
		wr(0, 8'hF5);
		rd(6'h20, 8'h0F);
		chk("pinDirectionBit", 8'h0F, dirBit);
		chk("padOe", 8'h0F, padOe);
		chk("padPullup", 8'hF0, padPullup);
		chk("padOut", 8'h05, padOut);
		wr(1, 8'h3C);
		chk("pinOutputValueBit", 8'hC9, outBit);
		rd(6'h08, 8'hC9);
		rst_b = 1'b0;
		#1 chk("padOe", 8'h00, padOe);
		chk("padPullup", 8'h00, padPullup);
		@(negedge clk_sys);
		rst_b = 1'b1;
		rd(6'h20, 8'h00);
		chk("pinOutputValueBit", 8'h00, outBit);
		for (int c = 0; c < 8; c++) begin
			wr(2, {8{c[2]}});
			wr(0, {8{c[1]}});
			globalPullupOff = c[0];
			#1 chk("padPullup", (c == 2) ? 8'hFF : 8'h00, padPullup);
			@(negedge clk_sys);
			{ovr[PE], ovr[PV]} = 16'hAA0F;
			#1 chk("padPullup", 8'h0A | ((c == 2) ? 8'h55 : 8'h00), padPullup);
			@(negedge clk_sys);
			ovr = '0;
		end
		globalPullupOff = 1'b0;
		wr(2, 8'hAA);
		wr(0, 8'h0F);
		{ovr[DE], ovr[DV], ovr[OE], ovr[OV]} = 32'hF0CC_3CFF;
		#1 chk("padOe", 8'hCA, padOe);
		chk("padOut", 8'h0A, padOut);
		@(negedge clk_sys);
		ovr = '0;
		wr(2, 8'h00);
		extLvl = 8'hFF;
		extIntEnable = 8'h01;
		{ovr[GE], ovr[GV]} = 16'h0602;
		for (int k = 1; k >= 0; k--) begin
			sleepClamp = k[0];
			gate = 8'h02 | (8'hF9 & (k[0] ? 8'h01 : 8'hFF));
			#1 chk("altDigitalIn", gate, altDigitalIn);
			@(negedge clk_sys);
		end
		ovr = '0;
		extLvl = 8'h00;
		repeat (3) @(negedge clk_sys);
		extLvl = 8'hA5;
		#1 chk("altDigitalIn", 8'hA5, altDigitalIn);
		chk("pinInputSampleBit", 8'h00, sampleBit);
		repeat (2) @(negedge clk_sys);
		chk("pinInputSampleBit", 8'hA5, sampleBit);
		rd(6'h30, 8'hA5);
		{anIn, anOut, anOe} = 24'h3C_C3_0F;
		#1 chk("altAnalogIn", 8'h3C, altAnalogIn);
		chk("padAnalogOut", 8'hC3, padAnalogOut);
		chk("padAnalogOe", 8'h0F, padAnalogOe);
		report_and_stop();
	end
endmodule

`default_nettype wire
